/* File: rtl/tfd_cfg.svh */
/*
 * task-file decoder constants: bit positions, register addresses and reset values.
 * assumes it is included by bare name from the package and the design modules.
 */
`ifndef TFD_CFG_SVH
`define TFD_CFG_SVH

// ------------------------------------------------------------
// register addresses on da[2:0]
// ------------------------------------------------------------
`define TFD_DA_DATA     3'h0
`define TFD_DA_FEAT     3'h1
`define TFD_DA_SCNT     3'h2
`define TFD_DA_SNUM     3'h3
`define TFD_DA_CYLL     3'h4
`define TFD_DA_CYLH     3'h5
`define TFD_DA_DEVH     3'h6
`define TFD_DA_CMD      3'h7
`define TFD_DA_DCTL     3'h6

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TFD_ST_BSY      7
`define TFD_ST_DRQ      3
`define TFD_DH_DEV      4
`define TFD_DC_NIEN     1
`define TFD_DC_SRST     2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TFD_RST_REG     8'h00
`define TFD_RST_WORD    16'h0000

`endif

/* File: rtl/tfd_pkg.sv */
/*
 * task-file decoder types: host pin bundle, register selector, shadow register set.
 * assumes tfd_cfg.svh is on the include path.
 */
package tfd_pkg;
    `include "tfd_cfg.svh"

    // ------------------------------------------------------------
    // host pin bundle, all active-low strobes and selects
    // ------------------------------------------------------------
    typedef struct packed {
        logic       cs0_n;
        logic       cs1_n;
        logic [2:0] da;
        logic       dior_n;
        logic       diow_n;
        logic       dmack_n;
    } tfd_host_t;

    // ------------------------------------------------------------
    // decoded register target
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TFD_R_NONE = 4'b0000,
        TFD_R_DATA = 4'b0001,
        TFD_R_FEAT = 4'b0010,
        TFD_R_SCNT = 4'b0011,
        TFD_R_SNUM = 4'b0100,
        TFD_R_CYLL = 4'b0101,
        TFD_R_CYLH = 4'b0110,
        TFD_R_DEVH = 4'b0111,
        TFD_R_CMD  = 4'b1000,
        TFD_R_DCTL = 4'b1001
    } tfd_reg_t;

    // ------------------------------------------------------------
    // command block shadow registers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] features;
        logic [7:0] sector_count;
        logic [7:0] sector_number;
        logic [7:0] cyl_low;
        logic [7:0] cyl_high;
        logic [7:0] dev_head;
        logic [7:0] command;
    } tfd_shadow_t;
endpackage : tfd_pkg

/* File: rtl/tfd_strobe_edge.sv */
/*
 * registers the host pins and data bus one cycle and flags the trailing
 * edge of each read and write strobe.
 * assumes host pins are already synchronous to core_clk.
 */
`timescale 1ns/10ps
`include "tfd_cfg.svh"
module tfd_strobe_edge
    import tfd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire tfd_host_t   host,
    input  wire logic [15:0] dd_in,
    output tfd_host_t        host_q,
    output logic [15:0]      dd_q,
    output logic             wr_end,
    output logic             rd_end
);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_q <= '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1, diow_n: 1'b1, dmack_n: 1'b1};
            dd_q   <= `TFD_RST_WORD;
        end else begin
            host_q <= host;
            dd_q   <= dd_in;
        end
    end

    // previous cycle held the strobe, this one has released it
    assign wr_end = !host_q.diow_n && host.diow_n;
    assign rd_end = !host_q.dior_n && host.dior_n;
endmodule : tfd_strobe_edge

/* File: rtl/tfd_task_file.sv */
/*
 * task-file register decode of a parallel storage device, pio cycles with
 * dmack_n negated: shadow registers, status substitution, pending interrupt.
 * assumes host pins synchronous to core_clk; status and error come from the
 * device core, which also raises irq_set when a command completes.
 */
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "tfd_cfg.svh"
// Contract
// R01: features loads when idle and no drq
// R02: shadow register write with drq is refused
// R03: host never writes registers while busy
// R04: features address read returns error
// R05: busy read returns status instead
// R06: sector count loads when idle
// R07: sector count read returns value
// R08: sector number loads and reads back
// R09: cylinder low loads and reads back
// R10: cylinder high loads and reads back
// R11: device/head loads, selection follows dev bit
// R12: device/head read returns value
// R13: command write starts command, clears pending
// R14: busy command write only clears pending
// R15: command address read gives status, clears pending
// R16: both chip selects asserted are ignored
// R17: respond only when dev bit matches
// R18: control write loads nien and srst
// R19: control read gives status, pending kept
// R20: data address with drq moves words
// R21: drive bus only during decoded read
module tfd_task_file
    import tfd_pkg::*;
#(
    parameter bit SUPPORT_DEVICE_RESET = 1'b1
)
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire tfd_host_t   host,
    input  wire logic [15:0] dd_in,
    output logic [15:0]      dd_out,
    output logic             dd_oe,
    input  wire logic        dev_num,
    input  wire logic [7:0]  status_in,
    input  wire logic [7:0]  error_in,
    input  wire logic        irq_set,
    input  wire logic [15:0] pio_rd_word,
    output tfd_shadow_t      shadow,
    output logic             cmd_start,
    output logic             dev_selected,
    output logic             nien,
    output logic             srst,
    output logic             irq_pending,
    output logic             intrq,
    output logic             pio_wr_stb,
    output logic [15:0]      pio_wr_word,
    output logic             pio_rd_stb,
    output logic             host_fault
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic tfd_reg_t decode(input tfd_host_t h);
        tfd_reg_t r;
        r = TFD_R_NONE;
        if (!h.dmack_n || (h.cs0_n == h.cs1_n)) begin  // R16
            r = TFD_R_NONE;
        end else if (!h.cs0_n) begin
            case (h.da)
                `TFD_DA_DATA: r = TFD_R_DATA;
                `TFD_DA_FEAT: r = TFD_R_FEAT;
                `TFD_DA_SCNT: r = TFD_R_SCNT;
                `TFD_DA_SNUM: r = TFD_R_SNUM;
                `TFD_DA_CYLL: r = TFD_R_CYLL;
                `TFD_DA_CYLH: r = TFD_R_CYLH;
                `TFD_DA_DEVH: r = TFD_R_DEVH;
                `TFD_DA_CMD:  r = TFD_R_CMD;
                default:      r = TFD_R_NONE;
            endcase
        end else if (h.da == `TFD_DA_DCTL) begin
            r = TFD_R_DCTL;
        end
        return r;
    endfunction : decode

    tfd_host_t   host_q;
    logic [15:0] dd_q;
    logic        wr_end;
    logic        rd_end;
    tfd_reg_t    wr_sel;
    tfd_reg_t    rd_sel;
    tfd_reg_t    rd_end_sel;
    logic        bsy;
    logic        drq;
    logic        shadow_sel;
    logic        wr_ok;
    logic        rd_live;
    logic [7:0]  devctl_reg;
    logic        pend_clr;
    logic [15:0] rd_next;

    tfd_strobe_edge u_edge (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .host     (host),
        .dd_in    (dd_in),
        .host_q   (host_q),
        .dd_q     (dd_q),
        .wr_end   (wr_end),
        .rd_end   (rd_end)
    );

    assign bsy          = status_in[`TFD_ST_BSY];
    assign drq          = status_in[`TFD_ST_DRQ];
    assign wr_sel       = wr_end ? decode(host_q) : TFD_R_NONE;
    assign rd_end_sel   = rd_end ? decode(host_q) : TFD_R_NONE;
    assign rd_sel       = host.dior_n ? TFD_R_NONE : decode(host);
    assign dev_selected = shadow.dev_head[`TFD_DH_DEV] == dev_num;  // R17
    assign shadow_sel   = (wr_sel >= TFD_R_FEAT) && (wr_sel <= TFD_R_DEVH);
    assign wr_ok        = !bsy && !drq;
    assign nien         = devctl_reg[`TFD_DC_NIEN];
    assign srst         = devctl_reg[`TFD_DC_SRST];
    assign intrq        = irq_pending && !nien && dev_selected;

    // ------------------------------------------------------------
    // shadow register writes
    // ------------------------------------------------------------
    // the shadow registers other than command are shared by both devices on the cable, so they load even
    // when this device is not selected; that is how the dev bit can change
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shadow <= '{default: `TFD_RST_REG};
        end else if (shadow_sel && wr_ok) begin
            case (wr_sel)
                TFD_R_FEAT: shadow.features      <= dd_q[7:0];  // R01
                TFD_R_SCNT: shadow.sector_count  <= dd_q[7:0];  // R06
                TFD_R_SNUM: shadow.sector_number <= dd_q[7:0];  // R08
                TFD_R_CYLL: shadow.cyl_low       <= dd_q[7:0];  // R09
                TFD_R_CYLH: shadow.cyl_high      <= dd_q[7:0];  // R10
                TFD_R_DEVH: shadow.dev_head      <= dd_q[7:0];  // R11
                default:    shadow.features      <= shadow.features;
            endcase
        end else if (wr_sel == TFD_R_CMD && wr_ok && dev_selected) begin
            shadow.command <= dd_q[7:0];  // R13
        end
    end

    // writes made while busy are left without effect, except device control and the pending clear of a command write (host must not do it)  R03
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_fault <= 1'b0;
        end else begin
            host_fault <= shadow_sel && !bsy && drq && dev_selected;  // R02
        end
    end

    // ------------------------------------------------------------
    // command start and device control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_start <= 1'b0;
        end else begin
            cmd_start <= wr_sel == TFD_R_CMD && wr_ok && dev_selected;  // R13
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            devctl_reg <= `TFD_RST_REG;
        end else if (wr_sel == TFD_R_DCTL) begin
            devctl_reg <= dd_q[7:0];  // R18
        end
    end

    // ------------------------------------------------------------
    // interrupt pending state, a new event wins over a clear
    // ------------------------------------------------------------
    always_comb begin
        pend_clr = 1'b0;
        if (dev_selected) begin
            if (wr_sel == TFD_R_CMD && (wr_ok || SUPPORT_DEVICE_RESET)) begin
                pend_clr = 1'b1;  // R13 R14
            end
            if (rd_end_sel == TFD_R_CMD) begin
                pend_clr = 1'b1;  // R15
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_pending <= 1'b0;
        end else if (irq_set) begin
            irq_pending <= 1'b1;
        end else if (pend_clr) begin
            irq_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pio data port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pio_wr_stb  <= 1'b0;
            pio_wr_word <= `TFD_RST_WORD;
            pio_rd_stb  <= 1'b0;
        end else begin
            pio_wr_stb <= wr_sel == TFD_R_DATA && !bsy && drq && dev_selected;  // R20
            pio_rd_stb <= rd_end_sel == TFD_R_DATA && !bsy && drq && dev_selected;  // R20
            if (wr_sel == TFD_R_DATA && !bsy && drq && dev_selected) begin
                pio_wr_word <= dd_q;
            end
        end
    end

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    always_comb begin
        rd_live = dev_selected && rd_sel != TFD_R_NONE;
        rd_next = {8'h00, status_in};
        case (rd_sel)
            TFD_R_DATA: begin
                rd_live = rd_live && !bsy && drq;
                rd_next = pio_rd_word;  // R20
            end
            TFD_R_FEAT: rd_next = bsy ? {8'h00, status_in} : {8'h00, error_in};  // R04 R05
            TFD_R_SCNT: rd_next = bsy ? {8'h00, status_in} : {8'h00, shadow.sector_count};  // R07 R05
            TFD_R_SNUM: rd_next = bsy ? {8'h00, status_in} : {8'h00, shadow.sector_number};  // R08 R05
            TFD_R_CYLL: rd_next = bsy ? {8'h00, status_in} : {8'h00, shadow.cyl_low};  // R09 R05
            TFD_R_CYLH: rd_next = bsy ? {8'h00, status_in} : {8'h00, shadow.cyl_high};  // R10 R05
            TFD_R_DEVH: rd_next = bsy ? {8'h00, status_in} : {8'h00, shadow.dev_head};  // R12 R05
            TFD_R_CMD:  rd_next = {8'h00, status_in};  // R15
            TFD_R_DCTL: rd_next = {8'h00, status_in};  // R19
            default:    rd_next = {8'h00, status_in};
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dd_oe  <= 1'b0;
            dd_out <= `TFD_RST_WORD;
        end else begin
            dd_oe  <= rd_live;  // R21
            dd_out <= rd_live ? rd_next : `TFD_RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_idle_write(tfd_reg_t r);
        wr_sel == r && !bsy && !drq;
    endsequence

    sequence s_pulse_once(logic sig);
        sig ##1 !sig;
    endsequence

    property p_feat_load;
        @(posedge core_clk) disable iff (!arst_n)
        s_idle_write(TFD_R_FEAT) |=> shadow.features == $past(dd_q[7:0]);
    endproperty
    a_feat_load: assert property (p_feat_load) else $error("features not loaded"); // R01

    property p_drq_refuse;
        @(posedge core_clk) disable iff (!arst_n)
        (shadow_sel && !bsy && drq && dev_selected) |=> $stable(shadow) && host_fault;
    endproperty
    a_drq_refuse: assert property (p_drq_refuse) else $error("write taken while drq set"); // R02

    property p_err_read;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_sel == TFD_R_FEAT && dev_selected && !bsy) |=> dd_oe && dd_out == {8'h00, $past(error_in)};
    endproperty
    a_err_read: assert property (p_err_read) else $error("error register not returned"); // R04

    property p_bsy_status;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_sel >= TFD_R_FEAT && rd_sel <= TFD_R_DEVH && dev_selected && bsy)
            |=> dd_out == {8'h00, $past(status_in)};
    endproperty
    a_bsy_status: assert property (p_bsy_status) else $error("status not substituted"); // R05

    property p_cmd_start;
        @(posedge core_clk) disable iff (!arst_n)
        (s_idle_write(TFD_R_CMD) and dev_selected && !irq_set)
            |=> s_pulse_once(cmd_start) and (shadow.command == $past(dd_q[7:0]) && !irq_pending);
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command write mishandled"); // R13

    property p_stat_rd_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_end_sel == TFD_R_CMD && dev_selected && !irq_set) |=> !irq_pending;
    endproperty
    a_stat_rd_clear: assert property (p_stat_rd_clear) else $error("pending not cleared"); // R15

    property p_both_cs;
        @(posedge core_clk) disable iff (!arst_n)
        (!host.cs0_n && !host.cs1_n) |=> !dd_oe;
    endproperty
    a_both_cs: assert property (p_both_cs) else $error("bus driven with both selects"); // R16

    property p_dctl;
        @(posedge core_clk) disable iff (!arst_n)
        (wr_sel == TFD_R_DCTL) |=> nien == $past(dd_q[`TFD_DC_NIEN]) && srst == $past(dd_q[`TFD_DC_SRST]);
    endproperty
    a_dctl: assert property (p_dctl) else $error("device control not loaded"); // R18

    property p_dctl_read;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_end_sel == TFD_R_DCTL && !irq_set) |=> irq_pending == $past(irq_pending);
    endproperty
    a_dctl_read: assert property (p_dctl_read) else $error("control read changed pending"); // R19

    property p_release;
        @(posedge core_clk) disable iff (!arst_n)
        host.dior_n |=> !dd_oe;
    endproperty
    a_release: assert property (p_release) else $error("bus driven without read"); // R21

    property p_unselected;
        @(posedge core_clk) disable iff (!arst_n)
        !dev_selected |=> !dd_oe && !cmd_start;
    endproperty
    a_unselected: assert property (p_unselected) else $error("unselected device answered"); // R17
endmodule : tfd_task_file

/* File: bench/tfd_host_model.sv */
/*
 * host adapter model: drives chip selects, address, strobes and write data.
 * assumes the caller runs one cycle at a time on core_clk.
 */
`timescale 1ns/10ps
module tfd_host_model
    import tfd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic [15:0] dd_out,
    input  wire logic        dd_oe,
    output tfd_host_t        host,
    output logic [15:0]      dd_in
);
    logic dmack_low = 1'b0;

    initial begin
        host  = '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1, diow_n: 1'b1, dmack_n: 1'b1};
        dd_in = 16'h0000;
    end

    // ------------------------------------------------------------
    // one strobe cycle: four cycles low, sample read data late
    // ------------------------------------------------------------
    task automatic cycle(input logic rd, input logic [1:0] csn, input logic [2:0] a,
                         input logic [15:0] wv, output logic [15:0] rv, output logic oe);
        @(posedge core_clk);
        host.cs0_n   <= csn[0];
        host.cs1_n   <= csn[1];
        host.da      <= a;
        host.dmack_n <= ~dmack_low;
        dd_in        <= wv;
        host.dior_n  <= ~rd;
        host.diow_n  <= rd;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rv = dd_out;
        oe = dd_oe;
        @(posedge core_clk);
        host.dior_n <= 1'b1;
        host.diow_n <= 1'b1;
        // released lines show the inverse, not the last value
        @(posedge core_clk);
        host.cs0_n   <= 1'b1;
        host.cs1_n   <= 1'b1;
        host.dmack_n <= 1'b1;
        host.da      <= ~a;
        dd_in        <= ~wv;
    endtask : cycle
endmodule : tfd_host_model

/* File: bench/testbench.sv */
/*
 * self-checking bench of the task-file decoder with a host adapter model.
 * assumes the default SUPPORT_DEVICE_RESET and a 40 MHz core_clk.
 */
`timescale 1ns/10ps
module testbench;
    import tfd_pkg::*;

    typedef struct packed {
        logic [2:0] da;
        logic [7:0] wv;
        logic [7:0] ex;
    } tfd_tb_row_t;

    localparam tfd_tb_row_t ROWS [6] = '{'{3'h1, 8'h77, 8'h04}, '{3'h2, 8'h5a, 8'h5a},
        '{3'h3, 8'ha5, 8'ha5}, '{3'h4, 8'h3c, 8'h3c}, '{3'h5, 8'hc3, 8'hc3}, '{3'h6, 8'ha0, 8'ha0}};

    logic        core_clk    = 1'b0;
    logic        arst_n      = 1'b0;
    tfd_host_t   host;
    logic [15:0] dd_in;
    logic [15:0] dd_out;
    logic        dd_oe;
    logic        dev_num     = 1'b0;
    logic [7:0]  status_in   = 8'h00;
    logic [7:0]  error_in    = 8'h04;
    logic        irq_set     = 1'b0;
    logic [15:0] pio_rd_word = 16'h1234;
    tfd_shadow_t shadow;
    logic        cmd_start, dev_selected, nien, srst, irq_pending, intrq;
    logic        pio_wr_stb, pio_rd_stb, host_fault;
    logic [15:0] pio_wr_word, last_pw;
    int          n_fail = 0, cmp_count = 0, n_start = 0, n_flt = 0, n_pw = 0, n_pr = 0;

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    tfd_host_model hm (.core_clk(core_clk), .dd_out(dd_out), .dd_oe(dd_oe), .host(host), .dd_in(dd_in));

    tfd_task_file dut (.core_clk(core_clk), .arst_n(arst_n), .host(host), .dd_in(dd_in), .dd_out(dd_out),
        .dd_oe(dd_oe), .dev_num(dev_num), .status_in(status_in), .error_in(error_in), .irq_set(irq_set),
        .pio_rd_word(pio_rd_word), .shadow(shadow), .cmd_start(cmd_start), .dev_selected(dev_selected),
        .nien(nien), .srst(srst), .irq_pending(irq_pending), .intrq(intrq), .pio_wr_stb(pio_wr_stb),
        .pio_wr_word(pio_wr_word), .pio_rd_stb(pio_rd_stb), .host_fault(host_fault));

    // ------------------------------------------------------------
    // pulse counters
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (cmd_start === 1'b1) n_start++;
        if (host_fault === 1'b1) n_flt++;
        if (pio_rd_stb === 1'b1) n_pr++;
        if (pio_wr_stb === 1'b1) begin
            n_pw++;
            last_pw = pio_wr_word;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic settle;
        repeat (3) @(negedge core_clk);
    endtask : settle

    task automatic set_st(input logic [7:0] v);
        @(posedge core_clk);
        status_in <= v;
    endtask : set_st

    task automatic irq_pulse;
        @(posedge core_clk);
        irq_set <= 1'b1;
        @(posedge core_clk);
        irq_set <= 1'b0;
    endtask : irq_pulse

    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #125000;
        n_fail++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [15:0] rv;
        logic        oe;
        int          ps;
        repeat (15) @(posedge core_clk);
        @(negedge core_clk);
        chk({8'h00, shadow}, 64'h0);
        chk(64'(dd_oe), 64'h0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            hm.cycle(1'b0, 2'b10, ROWS[i].da, {8'h00, ROWS[i].wv}, rv, oe);
            hm.cycle(1'b1, 2'b10, ROWS[i].da, 16'hffff, rv, oe);
            chk(64'(rv), 64'(ROWS[i].ex));
            chk(64'(oe), 64'h1);
        end
        settle();
        chk(64'(shadow.features), 64'h77);
        chk(64'(dd_oe), 64'h0);
        chk(64'(dev_selected), 64'h1);
        // drq set: register writes refused, data port moves words
        set_st(8'h08);
        ps = n_flt;
        hm.cycle(1'b0, 2'b10, 3'h2, 16'h0011, rv, oe);
        settle();
        chk(64'(n_flt - ps), 64'h1);
        hm.cycle(1'b1, 2'b10, 3'h2, 16'hffff, rv, oe);
        chk(64'(rv), 64'h5a);
        ps = n_pw;
        hm.cycle(1'b0, 2'b10, 3'h0, 16'hbeef, rv, oe);
        settle();
        chk(64'(n_pw - ps), 64'h1);
        chk(64'(last_pw), 64'hbeef);
        ps = n_pr;
        hm.cycle(1'b1, 2'b10, 3'h0, 16'hffff, rv, oe);
        settle();
        chk(64'(rv), 64'h1234);
        chk(64'(n_pr - ps), 64'h1);
        // busy: reads give status; a command write only clears pending
        set_st(8'h81);
        for (int a = 1; a < 7; a++) begin
            hm.cycle(1'b1, 2'b10, 3'(a), 16'hffff, rv, oe);
            chk(64'(rv), 64'h81);
        end
        irq_pulse();
        hm.cycle(1'b1, 2'b01, 3'h6, 16'hffff, rv, oe);
        settle();
        chk(64'(rv), 64'h81);
        chk(64'(irq_pending), 64'h1);
        hm.cycle(1'b1, 2'b10, 3'h7, 16'hffff, rv, oe);
        settle();
        chk(64'(rv), 64'h81);
        chk(64'(irq_pending), 64'h0);
        irq_pulse();
        ps = n_start;
        hm.cycle(1'b0, 2'b10, 3'h7, 16'h00ec, rv, oe);
        settle();
        chk(64'(n_start - ps), 64'h0);
        chk(64'(irq_pending), 64'h0);
        chk(64'(shadow.command), 64'h0);
        set_st(8'h00);
        irq_pulse();
        hm.cycle(1'b0, 2'b10, 3'h7, 16'h00ec, rv, oe);
        settle();
        chk(64'(n_start - ps), 64'h1);
        chk(64'(shadow.command), 64'hec);
        chk(64'(irq_pending), 64'h0);
        // both selects, and dma acknowledge, are ignored
        hm.cycle(1'b0, 2'b00, 3'h2, 16'h0099, rv, oe);
        hm.cycle(1'b1, 2'b00, 3'h2, 16'hffff, rv, oe);
        chk(64'(oe), 64'h0);
        hm.dmack_low <= 1'b1;
        hm.cycle(1'b1, 2'b10, 3'h2, 16'hffff, rv, oe);
        hm.dmack_low <= 1'b0;
        chk(64'(oe), 64'h0);
        settle();
        chk(64'(shadow.sector_count), 64'h5a);
        // device control: nien masks the line, srst follows
        hm.cycle(1'b0, 2'b01, 3'h6, 16'h0006, rv, oe);
        irq_pulse();
        settle();
        chk(64'({nien, srst}), 64'h3);
        chk(64'(intrq), 64'h0);
        hm.cycle(1'b0, 2'b01, 3'h6, 16'h0000, rv, oe);
        settle();
        chk(64'({nien, srst}), 64'h0);
        chk(64'(intrq), 64'h1);
        // other device selected: no drive, no command
        hm.cycle(1'b0, 2'b10, 3'h6, 16'h00b0, rv, oe);
        settle();
        chk(64'(dev_selected), 64'h0);
        hm.cycle(1'b1, 2'b10, 3'h2, 16'hffff, rv, oe);
        chk(64'(oe), 64'h0);
        ps = n_start;
        hm.cycle(1'b0, 2'b10, 3'h7, 16'h00ec, rv, oe);
        settle();
        chk(64'(n_start - ps), 64'h0);
        hm.cycle(1'b0, 2'b10, 3'h6, 16'h00a0, rv, oe);
        settle();
        chk(64'(dev_selected), 64'h1);
        close_out();
    end
endmodule : testbench
